// ### rtl/csl_regs.svh
// Contract
// R1 - The safety limit register returns to its default only on a short-battery detect or a low safety-limit reset pin; code also resets it on sys_rst.
// R2 - After such a reset the safety limit register accepts writes only until the first write to any other register.
// R3 - The regulation voltage at 02 and fast charge current at 04 never exceed the programmed safety maxima.
// R4 - The host must write the safety limit register first, else the default limits hold until the next safety-limit reset.
// R5 - The maximum charge current field is a 37.4 mV offset plus weighted bits, default 64.6 mV, largest 105.4 mV.
// R6 - The maximum regulation voltage field is a 4.2 V offset plus weighted bits, default 4.2 V, highest 4.44 V.
// R7 - Termination setting is 3.4 mV plus bits of 13.6, 6.8 and 3.4 mV.
// R8 - Charge setting is 37.4 mV plus bits of 54.4, 27.2, 13.6 and 6.8 mV.
// R9 - A charge cycle ends when charge current falls to the termination level while termination is enabled.
// R10 - After termination a new cycle starts when battery voltage drops below the refresh threshold.
// R11 - If fast-charge is not reached before the safety timer expires, the pack is flagged defective and charging stops.
// R12 - No register or pin can disable the safety timer.
// R13 - Below the 2 V short threshold the short-circuit mode limits charge current to about 30 mA.
// R14 - Safety limit bits 7:4 hold max current (54.4..6.8 mV) and bits 3:0 max voltage (160..20 mV).
// R15 - Regulation voltage field is 3.5 V plus 20 mV steps in bits 7:2, up to 4.44 V.
// R16 - The lock flag clears under exactly the conditions that reset the safety limit register.
// R17 - Clamping compares encoded fields with the maximum and substitutes the maximum when exceeded.
`ifndef CSL_REGS_SVH
`define CSL_REGS_SVH
// ============================================================
// Register offsets
`define CSL_ADDR_CTRL 3'h1
`define CSL_ADDR_VREG 3'h2
`define CSL_ADDR_IDENT 3'h3
`define CSL_ADDR_CURR 3'h4
`define CSL_ADDR_SPEC 3'h5
`define CSL_ADDR_LIMIT 3'h6
// ============================================================
// Reset values
`define CSL_RST_LIMIT 8'h40
`define CSL_RST_VREG 8'h0A
`define CSL_RST_CURR 8'h01
`define CSL_RST_CTRL 8'h08
// ============================================================
// Field positions
`define CSL_LIM_IMAX_HI 7
`define CSL_LIM_IMAX_LO 4
`define CSL_LIM_VMAX_HI 3
`define CSL_LIM_VMAX_LO 0
`define CSL_VREG_HI 7
`define CSL_VREG_LO 2
`define CSL_CURR_RST_BIT 7
`define CSL_CURR_CHG_HI 6
`define CSL_CURR_CHG_LO 3
`define CSL_CURR_TRM_HI 2
`define CSL_CURR_TRM_LO 0
`define CSL_CTRL_TERM_EN_BIT 3
// ============================================================
// Encodings, in sense microvolts and millivolts
`define CSL_CHG_OFFSET_UV 37400
`define CSL_CHG_STEP_UV 6800
`define CSL_TRM_OFFSET_UV 3400
`define CSL_TRM_STEP_UV 3400
`define CSL_VREG_OFFSET_MV 3500
`define CSL_VLIM_OFFSET_MV 4200
`define CSL_V_STEP_MV 20
`define CSL_VREG_MAX_MV 4440
`define CSL_IMAX_LARGEST_UV 105400
// Vmax 4.2 V in 20 mV steps above 3.5 V
`define CSL_VLIM_BASE_STEPS 6'd35
// ============================================================
// Timing
`define CSL_SAFETY_TIME_S 1800
`define CSL_CLK_HZ 100000000
`endif

// ### rtl/csl_pkg.sv
package csl_pkg;
	typedef enum logic [2:0] {
		CSL_IDLE = 3'b000,
		CSL_SHORT = 3'b001,
		CSL_PRE = 3'b010,
		CSL_FAST = 3'b011,
		CSL_DONE = 3'b100,
		CSL_FAULT = 3'b101
	} csl_state_e;
	typedef logic [7:0] csl_byte_t;
endpackage

// ### rtl/csl_clamp.sv
`timescale 1ns/1ps
// ============================================================
// Min of a programmed code and a maximum code
module csl_clamp #(
	parameter int W = 4
) (
	input wire logic [W-1:0] setCode, // Programmed code
	input wire logic [W-1:0] maxCode, // Safety maximum code
	output logic [W-1:0] outCode // Effective code
);
	always_comb begin
		outCode = (setCode > maxCode) ? maxCode : setCode; // R17
	end
endmodule

// ### rtl/csl_limit_lock.sv
`timescale 1ns/1ps
`include "csl_regs.svh"
module csl_limit_lock #(
	parameter longint SAFETY_CYCLES =
		longint'(`CSL_SAFETY_TIME_S) * longint'(`CSL_CLK_HZ)
) (
	input wire logic clk, // Core clock
	input wire logic sys_rst, // Synchronous reset, high
	input wire logic safety_limit_reset_n, // Limit reset pin, low
	input wire logic shortDetect, // Sense output below short threshold
	input wire logic wrEn, // Register write strobe
	input wire logic rdEn, // Register read strobe
	input wire logic [2:0] regAddr, // Register location
	input wire logic [7:0] wrData, // Write data
	input wire logic chargeEnable, // Charger may run
	input wire logic aboveFastThresh, // Battery in fast-charge region
	input wire logic belowRefresh, // Battery below refresh threshold
	input wire logic currentAtTerm, // Current at termination level
	output logic [7:0] rdData, // Read data
	output logic limitLocked, // Safety limit locked
	output logic [5:0] vregEff, // Clamped regulation voltage code
	output logic [3:0] charge_sense_setting, // Clamped charge code
	output logic [2:0] termination_sense_setting, // Termination code
	output logic shortMode, // Short-circuit charge mode
	output logic charging, // Charge cycle active
	output logic packDefective, // Safety timer fault
	output logic chargerReset // Reset pulse from location 04
);
	// ========================================================
	// Register state
	csl_pkg::csl_byte_t limit_r, limit_nxt;
	csl_pkg::csl_byte_t vreg_r, vreg_nxt;
	csl_pkg::csl_byte_t curr_r, curr_nxt;
	csl_pkg::csl_byte_t ctrl_r, ctrl_nxt;
	logic lock_r, lock_nxt;
	logic rstPulse_r, rstPulse_nxt;
	logic limitReset;
	always_comb begin
		limitReset = shortDetect | ~safety_limit_reset_n; // R1
		limit_nxt = limit_r;
		lock_nxt = lock_r;
		vreg_nxt = vreg_r;
		curr_nxt = curr_r;
		ctrl_nxt = ctrl_r;
		rstPulse_nxt = 1'b0;
		if (wrEn) begin
			case (regAddr)
				`CSL_ADDR_LIMIT: begin
					if (!lock_r) begin
						limit_nxt = wrData; // R2
					end
				end
				`CSL_ADDR_VREG: begin
					vreg_nxt = wrData;
				end
				`CSL_ADDR_CURR: begin
					curr_nxt = wrData;
					curr_nxt[`CSL_CURR_RST_BIT] = 1'b0;
					rstPulse_nxt = wrData[`CSL_CURR_RST_BIT];
				end
				`CSL_ADDR_CTRL: begin
					ctrl_nxt = wrData;
				end
				default: begin
				end
			endcase
			if (regAddr != `CSL_ADDR_LIMIT) begin
				lock_nxt = 1'b1; // R2 R4
			end
		end
		if (limitReset) begin
			limit_nxt = `CSL_RST_LIMIT; // R1
			lock_nxt = 1'b0; // R16
		end
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			limit_r <= `CSL_RST_LIMIT;
			lock_r <= 1'b0;
			vreg_r <= `CSL_RST_VREG;
			curr_r <= `CSL_RST_CURR;
			ctrl_r <= `CSL_RST_CTRL;
			rstPulse_r <= 1'b0;
		end else begin
			limit_r <= limit_nxt;
			lock_r <= lock_nxt;
			vreg_r <= vreg_nxt;
			curr_r <= curr_nxt;
			ctrl_r <= ctrl_nxt;
			rstPulse_r <= rstPulse_nxt;
		end
	end
	// ========================================================
	// Clamping against the safety maxima
	localparam logic [5:0] VREG_TOP = 6'((`CSL_VREG_MAX_MV
		- `CSL_VREG_OFFSET_MV) / `CSL_V_STEP_MV);
	localparam logic [3:0] IMAX_TOP = 4'((`CSL_IMAX_LARGEST_UV
		- `CSL_CHG_OFFSET_UV) / `CSL_CHG_STEP_UV);
	logic [5:0] vMaxSum;
	logic [5:0] vMaxCode;
	logic [3:0] iMaxCode;
	logic [5:0] vregClamped;
	logic [3:0] chgClamped;
	// R6 R14 R15: Vmax code in 20 mV steps above 3.5 V
	assign vMaxSum = `CSL_VLIM_BASE_STEPS
		+ {2'b00, limit_r[`CSL_LIM_VMAX_HI:`CSL_LIM_VMAX_LO]};
	// Limit codes above the highest option select the highest option
	csl_clamp #(.W(6)) uVTop (
		.setCode(vMaxSum),
		.maxCode(VREG_TOP),
		.outCode(vMaxCode)
	); // R6
	csl_clamp #(.W(4)) uITop (
		.setCode(limit_r[`CSL_LIM_IMAX_HI:`CSL_LIM_IMAX_LO]),
		.maxCode(IMAX_TOP),
		.outCode(iMaxCode)
	); // R5
	csl_clamp #(.W(6)) uVClamp (
		.setCode(vreg_r[`CSL_VREG_HI:`CSL_VREG_LO]),
		.maxCode(vMaxCode),
		.outCode(vregClamped)
	); // R3
	// R5 R8: both current fields share 37.4 mV offset and 6.8 mV step
	csl_clamp #(.W(4)) uIClamp (
		.setCode(curr_r[`CSL_CURR_CHG_HI:`CSL_CURR_CHG_LO]),
		.maxCode(iMaxCode),
		.outCode(chgClamped)
	); // R3
	// ========================================================
	// Charge sequencing with safety timer
	csl_pkg::csl_state_e state_r, state_nxt;
	logic [63:0] timer_r, timer_nxt;
	logic termEn;
	always_comb begin
		termEn = ctrl_r[`CSL_CTRL_TERM_EN_BIT];
		state_nxt = state_r;
		timer_nxt = timer_r;
		case (state_r)
			csl_pkg::CSL_IDLE: begin
				timer_nxt = 64'h0;
				if (chargeEnable) begin
					state_nxt = shortDetect ? csl_pkg::CSL_SHORT
						: csl_pkg::CSL_PRE;
				end
			end
			csl_pkg::CSL_SHORT, csl_pkg::CSL_PRE: begin
				timer_nxt = timer_r + 64'h1; // R12
				if (aboveFastThresh) begin
					state_nxt = csl_pkg::CSL_FAST;
				end else if (timer_r >= 64'(SAFETY_CYCLES - 1)) begin
					state_nxt = csl_pkg::CSL_FAULT; // R11
				end else begin
					state_nxt = shortDetect ? csl_pkg::CSL_SHORT
						: csl_pkg::CSL_PRE; // R13
				end
			end
			csl_pkg::CSL_FAST: begin
				if (termEn && currentAtTerm) begin
					state_nxt = csl_pkg::CSL_DONE; // R9
				end
			end
			csl_pkg::CSL_DONE: begin
				timer_nxt = 64'h0;
				if (belowRefresh) begin
					state_nxt = csl_pkg::CSL_PRE; // R10
				end
			end
			csl_pkg::CSL_FAULT: begin
			end
			default: begin
				state_nxt = csl_pkg::CSL_IDLE;
			end
		endcase
		if (!chargeEnable || rstPulse_r) begin
			if (state_r != csl_pkg::CSL_FAULT || rstPulse_r) begin
				state_nxt = csl_pkg::CSL_IDLE;
			end
		end
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_r <= csl_pkg::CSL_IDLE;
			timer_r <= 64'h0;
		end else begin
			state_r <= state_nxt;
			timer_r <= timer_nxt;
		end
	end
	// ========================================================
	// Registered outputs
	csl_pkg::csl_byte_t rd_nxt;
	always_comb begin
		rd_nxt = 8'h00;
		if (rdEn) begin
			case (regAddr)
				`CSL_ADDR_LIMIT: rd_nxt = limit_r;
				`CSL_ADDR_VREG: rd_nxt = vreg_r;
				`CSL_ADDR_CURR: rd_nxt = curr_r;
				`CSL_ADDR_CTRL: rd_nxt = ctrl_r;
				default: rd_nxt = 8'h00;
			endcase
		end
	end
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rdData <= 8'h00;
			limitLocked <= 1'b0;
			vregEff <= 6'h00;
			charge_sense_setting <= 4'h0;
			termination_sense_setting <= 3'h0;
			shortMode <= 1'b0;
			charging <= 1'b0;
			packDefective <= 1'b0;
			chargerReset <= 1'b0;
		end else begin
			rdData <= rd_nxt;
			limitLocked <= lock_r;
			vregEff <= vregClamped;
			charge_sense_setting <= chgClamped;
			termination_sense_setting <=
				curr_r[`CSL_CURR_TRM_HI:`CSL_CURR_TRM_LO]; // R7
			shortMode <= (state_r == csl_pkg::CSL_SHORT); // R13
			charging <= (state_r == csl_pkg::CSL_SHORT)
				| (state_r == csl_pkg::CSL_PRE)
				| (state_r == csl_pkg::CSL_FAST);
			packDefective <= (state_r == csl_pkg::CSL_FAULT); // R11
			chargerReset <= rstPulse_r;
		end
	end
endmodule

// ### bench/csl_limit_lock_chk.sv
`timescale 1ns/1ps
module csl_limit_lock_chk #(
	parameter longint SAFETY_CYCLES = 20
) (
	input wire logic clk, // Clock
	input wire logic sys_rst, // Reset
	input wire logic safety_limit_reset_n, // Limit reset pin
	input wire logic shortDetect, // Short detect
	input wire logic wrEn, // Write strobe
	input wire logic rdEn, // Read strobe
	input wire logic [2:0] regAddr, // Location
	input wire logic aboveFastThresh, // Fast region
	input wire logic [7:0] rdData, // Read data
	input wire logic limitLocked, // Lock flag
	input wire logic [5:0] vregEff, // Voltage code
	input wire logic [3:0] charge_sense_setting, // Current code
	input wire logic charging, // Charging
	input wire logic packDefective // Fault
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	wire clrOff = safety_limit_reset_n && !shortDetect;
	longint preCnt_r;
	always_ff @(posedge clk) begin
		if (sys_rst || !charging || aboveFastThresh) preCnt_r <= 0;
		else preCnt_r <= preCnt_r + 1;
	end
	sequence s_other_wr;
		wrEn && regAddr != 3'h6 && clrOff ##1 clrOff;
	endsequence
	sequence s_quiet_clr;
		!safety_limit_reset_n ##1 (!wrEn)[*3];
	endsequence
	a_lock_write: assert property (s_other_wr |-> ##1 limitLocked)
		else $error("lock not set by other write");
	a_unlock_reset: assert property (!clrOff |-> ##2 !limitLocked)
		else $error("lock kept after limit reset");
	a_unlock_cause: assert property ($fell(limitLocked) |->
		!$past(clrOff, 2)) else $error("lock cleared without cause");
	a_default_clamp: assert property (s_quiet_clr |->
		charge_sense_setting <= 4'h4 && vregEff <= 6'h23)
		else $error("default limits not applied");
	a_vreg_max: assert property (vregEff <= 6'h2F)
		else $error("voltage code above highest option");
	a_imax_top: assert property (charge_sense_setting <= 4'hA)
		else $error("current code above largest option");
	a_fault_stop: assert property (packDefective |-> !charging)
		else $error("charging while pack faulted");
	a_timer_bound: assert property (preCnt_r < SAFETY_CYCLES + 4)
		else $error("safety timer did not expire");
	a_rd_idle: assert property (!$past(rdEn) |-> rdData == 8'h00)
		else $error("read data without read");
endmodule
bind csl_limit_lock csl_limit_lock_chk #(.SAFETY_CYCLES(SAFETY_CYCLES)) chk_i (
	.clk(clk), .sys_rst(sys_rst), .safety_limit_reset_n(safety_limit_reset_n),
	.shortDetect(shortDetect), .wrEn(wrEn), .rdEn(rdEn), .regAddr(regAddr),
	.aboveFastThresh(aboveFastThresh), .rdData(rdData),
	.limitLocked(limitLocked), .vregEff(vregEff),
	.charge_sense_setting(charge_sense_setting), .charging(charging),
	.packDefective(packDefective));

// ### bench/csl_host.sv
`timescale 1ns/1ps
module csl_host (
	input wire logic clk, // Clock
	input wire logic [7:0] rdData, // Read data
	output logic wrEn, // Write strobe
	output logic rdEn, // Read strobe
	output logic [2:0] regAddr, // Location
	output logic [7:0] wrData // Write data
);
	initial begin
		wrEn = 1'b0;
		rdEn = 1'b0;
		regAddr = 3'h0;
		wrData = 8'h00;
	end
	// Released bus lines show the inverse of the last value
	task wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		wrEn <= 1'b1;
		regAddr <= a;
		wrData <= d;
		@(posedge clk);
		wrEn <= 1'b0;
		regAddr <= ~a;
		wrData <= ~d;
	endtask
	task rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk);
		rdEn <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		rdEn <= 1'b0;
		regAddr <= ~a;
		#1 d = rdData;
	endtask
endmodule

// ### bench/csl_tb.sv
`timescale 1ns/1ps
module testbench;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic slRstN = 1'b1;
	logic shortDetect = 1'b0;
	logic chgEn = 1'b0;
	logic fast = 1'b0;
	logic refresh = 1'b0;
	logic atTerm = 1'b0;
	logic wrEn, rdEn, locked, shortMode, charging, fault, chgRst;
	logic [2:0] regAddr, termSet;
	logic [7:0] wrData, rdData, v;
	logic [5:0] vreg;
	logic [3:0] chgSet;
	int failures = 0;
	int samples_checked = 0;
	always #5 clk = ~clk;
	csl_host csl_host_inst (.clk(clk), .rdData(rdData), .wrEn(wrEn),
		.rdEn(rdEn), .regAddr(regAddr), .wrData(wrData));
	csl_limit_lock #(.SAFETY_CYCLES(20)) csl_limit_lock_inst (.clk(clk),
		.sys_rst(sys_rst), .safety_limit_reset_n(slRstN),
		.shortDetect(shortDetect), .wrEn(wrEn), .rdEn(rdEn),
		.regAddr(regAddr), .wrData(wrData), .chargeEnable(chgEn),
		.aboveFastThresh(fast), .belowRefresh(refresh),
		.currentAtTerm(atTerm), .rdData(rdData), .limitLocked(locked),
		.vregEff(vreg), .charge_sense_setting(chgSet),
		.termination_sense_setting(termSet), .shortMode(shortMode),
		.charging(charging), .packDefective(fault), .chargerReset(chgRst));
	task chk(input logic [15:0] s, input logic [15:0] e);
		samples_checked++;
		if (s !== e) begin
			failures++;
			$display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
		end
	endtask
	task rdc(input logic [2:0] a, input logic [7:0] e);
		csl_host_inst.rd(a, v);
		chk(v, e);
	endtask
	task tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task end_sim;
		if (failures == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task t_defaults;
		rdc(3'h6, 8'h40);
		rdc(3'h2, 8'h0A);
		rdc(3'h4, 8'h01);
		chk({chgSet, 1'b0, termSet, 7'h00, locked}, 16'h0100);
		chk({2'h0, vreg}, 8'h02);
	endtask
	task t_program;
		csl_host_inst.wr(3'h6, 8'h53);
		rdc(3'h6, 8'h53);
		csl_host_inst.wr(3'h2, 8'hFC);
		csl_host_inst.wr(3'h4, 8'hCD);
		tick(3);
		chk({2'h0, vreg}, 8'h26);
		chk({chgSet, 1'b0, termSet}, 8'h55);
		csl_host_inst.wr(3'h6, 8'h00);
		rdc(3'h6, 8'h53);
		rdc(3'h4, 8'h4D);
		chk({7'h00, locked}, 8'h01);
	endtask
	task t_clear(input logic usePin);
		@(posedge clk);
		if (usePin) slRstN <= 1'b0;
		else shortDetect <= 1'b1;
		@(posedge clk);
		slRstN <= 1'b1;
		shortDetect <= 1'b0;
		tick(3);
		chk({7'h00, locked}, 8'h00);
		chk({chgSet, 1'b0, termSet, 2'h0, vreg}, 16'h4523);
		rdc(3'h6, 8'h40);
		csl_host_inst.wr(3'h1, 8'h08);
		tick(2);
		chk({7'h00, locked}, 8'h01);
	endtask
	task t_timeout;
		@(posedge clk);
		chgEn <= 1'b1;
		for (int i = 0; i < 40 && fault !== 1'b1; i++) tick(1);
		chk({6'h00, fault, charging}, 8'h02);
		@(posedge clk);
		chgEn <= 1'b0;
		tick(3);
		chk({7'h00, fault}, 8'h01);
		csl_host_inst.wr(3'h4, 8'h80);
		tick(1);
		chk({7'h00, chgRst}, 8'h01);
		tick(1);
		chk({7'h00, chgRst}, 8'h00);
		tick(2);
		chk({7'h00, fault}, 8'h00);
	endtask
	task t_cycle;
		@(posedge clk);
		chgEn <= 1'b1;
		fast <= 1'b1;
		tick(4);
		chk({7'h00, charging}, 8'h01);
		@(posedge clk);
		atTerm <= 1'b1;
		tick(4);
		chk({7'h00, charging}, 8'h00);
		@(posedge clk);
		atTerm <= 1'b0;
		refresh <= 1'b1;
		tick(4);
		chk({7'h00, charging}, 8'h01);
		@(posedge clk);
		refresh <= 1'b0;
		chgEn <= 1'b0;
		fast <= 1'b0;
		shortDetect <= 1'b1;
		tick(3);
		@(posedge clk);
		chgEn <= 1'b1;
		tick(4);
		chk({7'h00, shortMode}, 8'h01);
		@(posedge clk);
		chgEn <= 1'b0;
		shortDetect <= 1'b0;
		tick(3);
	endtask
	task t_top;
		csl_host_inst.wr(3'h6, 8'hFF);
		csl_host_inst.wr(3'h2, 8'hFC);
		csl_host_inst.wr(3'h4, 8'h78);
		tick(3);
		chk({2'h0, vreg}, 8'h2F);
		chk({4'h0, chgSet}, 8'h0A);
		rdc(3'h6, 8'hFF);
	endtask
	initial begin
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		tick(2);
		t_defaults();
		t_program();
		t_clear(1'b1);
		t_clear(1'b0);
		t_timeout();
		t_cycle();
		t_top();
		end_sim();
	end
	initial begin
		#50000;
		failures++;
		end_sim();
	end
endmodule
